//--- core/but_prescaler.sv
// prescaler: divides the timer clock by shadow value plus one
`timescale 1ns/100ps
`default_nettype none
module but_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic clear,
  input wire logic [15:0] divide_value,
  // tick out
  output logic tick
);
  import but_pkg::*;
  logic [15:0] div_count_reg;
  logic [15:0] div_count_next;

  always_comb begin
    div_count_next = div_count_reg;
    tick = 1'b0;
    if (clear) begin
      div_count_next = RESET_HALF;
    end else if (run) begin
      if (div_count_reg >= divide_value) begin
        div_count_next = RESET_HALF;
        tick = 1'b1;
      end else begin
        div_count_next = div_count_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_count_reg <= RESET_HALF;
    end else begin
      div_count_reg <= div_count_next;
    end
  end
endmodule : but_prescaler
`default_nettype wire

//--- core/but_timer.sv
// basic 16-bit up-count timer with AHB-Lite register slave
// Behaviour
// - counter_run 0 holds the counter; 1 counts on prescaled ticks
// - trigger select 000 pulses trigger_output on every counter reset, forced too
// - trigger select 001 pulses trigger_output when counter_run becomes set
// - trigger select 010 pulses trigger_output on each update event, forced or overflow, whatever update_origin_select
// - update_dma_gate bit 8 allows update DMA requests
// - update_irq_gate bit 0 allows the update interrupt
// - update_flag set on update, cleared by writing zero, one ignored
// - writing one to force_update requests update; self-clearing, zero ignored
// - forced update clears counter and prescaler in the same cycle
// - count_value reads live count; a write replaces it at once, but a tick in the same cycle wins and the write is lost
// - counting tick is timer clock divided by prescale value plus one
// - new prescale value used only after copy at update event
// - reload_limit is the terminal count where counter wraps
// - count 0 to reload_limit, wrap to 0, update event on overflow
// - update_block: forced update reinitialises but no event nor reload
// - update_origin_select 1: only overflow sets flag, interrupt or DMA
// - one_shot clears counter_run at the next update event
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module but_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // timer outputs
  output logic update_irq,
  output logic update_dma_req,
  output logic trigger_output
);
  import but_pkg::*;

  // bus address phase capture
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_addr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  // control state
  logic [7:0] ctl0_reg;
  logic [7:0] ctl0_next;
  logic [2:0] trg_sel_reg;
  logic [2:0] trg_sel_next;
  logic irq_gate_reg;
  logic irq_gate_next;
  logic dma_gate_reg;
  logic dma_gate_next;
  logic flag_reg;
  logic flag_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] psc_reg;
  logic [15:0] psc_next;
  logic [15:0] psc_shadow_reg;
  logic [15:0] psc_shadow_next;
  logic [15:0] car_reg;
  logic [15:0] car_next;
  logic [15:0] car_shadow_reg;
  logic [15:0] car_shadow_next;
  logic dma_reg;
  logic dma_next;
  // event wires
  logic addr_phase;
  logic wr_now;
  logic tick;
  logic overflow;
  logic force_req;
  logic counter_reset;
  logic update_event;
  logic qualified_update;
  logic start_event;
  logic [15:0] limit;

  function automatic logic [31:0] but_half(input logic [15:0] v);
    but_half = {16'h0000, v};
  endfunction : but_half

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction : is_reg

  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign wr_now = wr_pend_reg;
  // no wait states: every access finishes in its first data-phase cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  // bus slave: writes land in the data phase, reads sampled in address phase
  always_comb begin
    wr_pend_next = addr_phase && hwrite;
    wr_addr_next = addr_phase ? haddr : wr_addr_reg;
    rdata_next = rdata_reg;
    if (addr_phase && !hwrite) begin
      rdata_next = RESET_WORD;
      if (is_reg(haddr, OFS_CONTROL_ZERO)) rdata_next = {24'h00_0000, ctl0_reg};
      if (is_reg(haddr, OFS_CONTROL_ONE)) begin
        rdata_next = {25'h000_0000, trg_sel_reg, 4'h0};
      end
      if (is_reg(haddr, OFS_IRQ_DMA_ENABLE)) begin
        rdata_next = {23'h00_0000, dma_gate_reg, 7'h00, irq_gate_reg};
      end
      if (is_reg(haddr, OFS_EVENT_FLAGS)) rdata_next = {31'h0000_0000, flag_reg};
      if (is_reg(haddr, OFS_COUNT_VALUE)) rdata_next = but_half(count_reg);
      if (is_reg(haddr, OFS_CLOCK_DIVIDER)) rdata_next = but_half(psc_reg);
      if (is_reg(haddr, OFS_RELOAD_VALUE)) rdata_next = but_half(car_reg);
    end
  end

  // force_update is a pulse: the bit never holds state, so it reads zero
  assign force_req = wr_now && is_reg(wr_addr_reg, OFS_SOFT_EVENT)
    && hwdata[BIT_FORCE_UPDATE];
  // reload_limit with or without its shadow copy
  assign limit = ctl0_reg[BIT_RELOAD_SHADOW] ? car_shadow_reg : car_reg;
  assign overflow = tick && (count_reg >= limit);
  assign counter_reset = force_req || overflow;
  // update_block suppresses every update event, forced or overflow
  assign update_event = counter_reset && !ctl0_reg[BIT_UPDATE_BLOCK];
  assign qualified_update = update_event
    && (overflow || !ctl0_reg[BIT_UPDATE_ORIGIN]);

  always_comb begin
    ctl0_next = ctl0_reg;
    trg_sel_next = trg_sel_reg;
    irq_gate_next = irq_gate_reg;
    dma_gate_next = dma_gate_reg;
    psc_next = psc_reg;
    car_next = car_reg;
    flag_next = flag_reg;
    count_next = count_reg;
    psc_shadow_next = psc_shadow_reg;
    car_shadow_next = car_shadow_reg;
    if (wr_now) begin
      if (is_reg(wr_addr_reg, OFS_CONTROL_ZERO)) begin
        ctl0_next = {hwdata[BIT_RELOAD_SHADOW], 3'b000, hwdata[3:0]};
      end
      if (is_reg(wr_addr_reg, OFS_CONTROL_ONE)) begin
        trg_sel_next = hwdata[TRG_SEL_HI:TRG_SEL_LO];
      end
      if (is_reg(wr_addr_reg, OFS_IRQ_DMA_ENABLE)) begin
        irq_gate_next = hwdata[BIT_UPDATE_IRQ_GATE];
        dma_gate_next = hwdata[BIT_UPDATE_DMA_GATE];
      end
      if (is_reg(wr_addr_reg, OFS_EVENT_FLAGS) && !hwdata[BIT_UPDATE_FLAG]) begin
        flag_next = 1'b0;
      end
      if (is_reg(wr_addr_reg, OFS_COUNT_VALUE)) count_next = hwdata[15:0];
      if (is_reg(wr_addr_reg, OFS_CLOCK_DIVIDER)) psc_next = hwdata[15:0];
      if (is_reg(wr_addr_reg, OFS_RELOAD_VALUE)) car_next = hwdata[15:0];
    end
    // counting: overflow and force both restart from zero
    if (counter_reset) begin
      count_next = RESET_HALF;
    end else if (tick) begin
      count_next = count_reg + 16'h0001;
    end
    if (update_event) begin
      psc_shadow_next = psc_next;
      car_shadow_next = car_next;
      if (ctl0_reg[BIT_ONE_SHOT]) ctl0_next[BIT_COUNTER_RUN] = 1'b0;
    end
    // hardware set wins over a same-cycle software clear
    if (qualified_update) flag_next = 1'b1;
  end

  assign dma_next = qualified_update && dma_gate_reg;
  assign start_event = ctl0_next[BIT_COUNTER_RUN] && !ctl0_reg[BIT_COUNTER_RUN];
  assign update_irq = flag_reg && irq_gate_reg;
  assign update_dma_req = dma_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg <= RESET_WORD;
      ctl0_reg <= 8'h00;
      trg_sel_reg <= 3'b000;
      irq_gate_reg <= 1'b0;
      dma_gate_reg <= 1'b0;
      flag_reg <= 1'b0;
      count_reg <= RESET_HALF;
      psc_reg <= RESET_HALF;
      psc_shadow_reg <= RESET_HALF;
      car_reg <= RESET_HALF;
      car_shadow_reg <= RESET_HALF;
      dma_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg <= rdata_next;
      ctl0_reg <= ctl0_next;
      trg_sel_reg <= trg_sel_next;
      irq_gate_reg <= irq_gate_next;
      dma_gate_reg <= dma_gate_next;
      flag_reg <= flag_next;
      count_reg <= count_next;
      psc_reg <= psc_next;
      psc_shadow_reg <= psc_shadow_next;
      car_reg <= car_next;
      car_shadow_reg <= car_shadow_next;
      dma_reg <= dma_next;
    end
  end

  but_prescaler u_prescaler (
    .clk(clk),
    .rst(rst),
    .run(ctl0_reg[BIT_COUNTER_RUN]),
    .clear(force_req),
    .divide_value(psc_shadow_reg),
    .tick(tick)
  );

  but_trigger u_trigger (
    .clk(clk),
    .rst(rst),
    .trg_sel(trg_sel_reg),
    .reset_event(counter_reset),
    .start_event(start_event),
    .update_event(update_event),
    .trigger_output(trigger_output)
  );

  AST_RUN_HOLDS: assert property (@(posedge clk) disable iff (rst)
    !ctl0_reg[BIT_COUNTER_RUN] && !wr_now |=> count_reg == $past(count_reg))
    else $error("counter moved while stopped");
  AST_TRG_RESET: assert property (@(posedge clk) disable iff (rst)
    counter_reset && trg_sel_reg == BUT_TRG_RESET |=> trigger_output)
    else $error("no trigger on counter reset");
  AST_TRG_START: assert property (@(posedge clk) disable iff (rst)
    start_event && trg_sel_reg == BUT_TRG_START |=> trigger_output)
    else $error("no trigger on start");
  AST_TRG_UPDATE: assert property (@(posedge clk) disable iff (rst)
    trg_sel_reg == BUT_TRG_UPDATE && !update_event |=> !trigger_output)
    else $error("trigger without update");
  AST_DMA_GATE: assert property (@(posedge clk) disable iff (rst)
    update_dma_req |-> $past(dma_gate_reg) && $past(qualified_update))
    else $error("dma request without gate or update");
  AST_IRQ: assert property (@(posedge clk) disable iff (rst)
    update_irq == (flag_reg && irq_gate_reg))
    else $error("interrupt does not follow flag and gate");
  AST_FLAG_SET: assert property (@(posedge clk) disable iff (rst)
    qualified_update |=> flag_reg)
    else $error("update flag not set");
  AST_FORCE_CLEAR: assert property (@(posedge clk) disable iff (rst)
    force_req |=> count_reg == RESET_HALF && u_prescaler.div_count_reg == RESET_HALF)
    else $error("forced update did not clear counters");
  AST_WRAP: assert property (@(posedge clk) disable iff (rst)
    overflow && !wr_now |=> count_reg == RESET_HALF)
    else $error("counter did not wrap");
  AST_SILENT_FORCE: assert property (@(posedge clk) disable iff (rst)
    force_req && ctl0_reg[BIT_UPDATE_ORIGIN] && !overflow && !flag_reg
    && !(wr_now && is_reg(wr_addr_reg, OFS_EVENT_FLAGS)) |=> !flag_reg)
    else $error("forced update set flag");
  AST_ONE_SHOT: assert property (@(posedge clk) disable iff (rst)
    update_event && ctl0_reg[BIT_ONE_SHOT] |=> !ctl0_reg[BIT_COUNTER_RUN])
    else $error("one shot did not stop");
endmodule : but_timer
`default_nettype wire

//--- core/but_trigger.sv
// trigger output selection from reset, start and update events
`timescale 1ns/100ps
`default_nettype none
module but_trigger (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // events
  input wire logic [2:0] trg_sel,
  input wire logic reset_event,
  input wire logic start_event,
  input wire logic update_event,
  // output
  output logic trigger_output
);
  import but_pkg::*;
  logic trg_reg;
  logic trg_next;

  always_comb begin
    case (trg_sel)
      BUT_TRG_RESET: trg_next = reset_event;
      BUT_TRG_START: trg_next = start_event;
      BUT_TRG_UPDATE: trg_next = update_event;
      default: trg_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trg_reg <= 1'b0;
    end else begin
      trg_reg <= trg_next;
    end
  end

  assign trigger_output = trg_reg;
endmodule : but_trigger
`default_nettype wire

//--- shared/but_pkg.sv
// constants, register map and types of the basic up-count timer
package but_pkg;
  localparam logic [7:0] OFS_CONTROL_ZERO = 8'h00;
  localparam logic [7:0] OFS_CONTROL_ONE = 8'h04;
  localparam logic [7:0] OFS_IRQ_DMA_ENABLE = 8'h0c;
  localparam logic [7:0] OFS_EVENT_FLAGS = 8'h10;
  localparam logic [7:0] OFS_SOFT_EVENT = 8'h14;
  localparam logic [7:0] OFS_COUNT_VALUE = 8'h24;
  localparam logic [7:0] OFS_CLOCK_DIVIDER = 8'h28;
  localparam logic [7:0] OFS_RELOAD_VALUE = 8'h2c;
  // control_zero fields
  localparam int BIT_COUNTER_RUN = 0;
  localparam int BIT_UPDATE_BLOCK = 1;
  localparam int BIT_UPDATE_ORIGIN = 2;
  localparam int BIT_ONE_SHOT = 3;
  localparam int BIT_RELOAD_SHADOW = 7;
  // control_one trigger select field
  localparam int TRG_SEL_LO = 4;
  localparam int TRG_SEL_HI = 6;
  // irq_dma_enable fields
  localparam int BIT_UPDATE_IRQ_GATE = 0;
  localparam int BIT_UPDATE_DMA_GATE = 8;
  // event_flags and soft_event fields
  localparam int BIT_UPDATE_FLAG = 0;
  localparam int BIT_FORCE_UPDATE = 0;
  localparam logic [15:0] RESET_HALF = 16'h0000;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  typedef enum logic [2:0] {
    BUT_TRG_RESET = 3'b000,
    BUT_TRG_START = 3'b001,
    BUT_TRG_UPDATE = 3'b010
  } but_trg_sel_t;
endpackage : but_pkg

//--- verification/basic_upcount_timer_tb.sv
// self-checking bench for the basic up-count timer
`timescale 1ns/100ps
`default_nettype none
module basic_upcount_timer_tb;
  import but_pkg::*;
  typedef struct {
    string name;
    logic [31:0] val;
  } but_note_t;
  logic clk, rst, hsel, hwrite, hready, rd_dp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, update_irq, update_dma_req, trigger_output;
  but_note_t notes[$];
  int err_count, n_checks, cyc, trg_n, dma_n, last_pulse, last_gap, t0, d0, gap_exp;
  logic [15:0] p_old, p_new, lim, cv;
  logic [23:0] row;
  // row: control_zero, trigger select, irq_dma_enable, then {irq, trigger, dma, flag}
  logic [23:0] rows[6] = '{24'h00_101f, 24'h01_1003, 24'h02_101f, 24'h22_1010,
                           24'h40_1014, 24'h02_001d};
  logic [7:0] ofs[9] = '{OFS_CONTROL_ZERO, OFS_CONTROL_ONE, OFS_IRQ_DMA_ENABLE,
                         OFS_EVENT_FLAGS, OFS_SOFT_EVENT, OFS_COUNT_VALUE,
                         OFS_CLOCK_DIVIDER, OFS_RELOAD_VALUE, 8'h30};

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  but_timer DUT (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .update_irq(update_irq),
    .update_dma_req(update_dma_req), .trigger_output(trigger_output)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // watcher: pulse counting, read data against the oldest note, hang limit
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      err_count++;
      report_and_stop();
    end
    if (update_dma_req === 1'b1) begin
      last_gap = cyc - last_pulse;
      last_pulse = cyc;
      dma_n++;
    end
    if (trigger_output === 1'b1) begin
      trg_n++;
    end
    if (rd_dp === 1'b1 && hready === 1'b1) begin
      check(notes[0].name, notes[0].val, hrdata);
      check("response", 32'h0000_0000, {31'h0, hresp});
      void'(notes.pop_front());
    end
  end

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp <= ~wr;
    do @(posedge clk); while (hready !== 1'b1);
    rd_dp <= 1'b0;
  endtask : bus

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    notes.push_back('{n, e});
    bus(1'b0, a, $urandom);
  endtask : rd

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n

  // bounded wait for the next dma pulse
  task automatic wait_dma;
    int d;
    d = dma_n;
    for (int i = 0; i < 2000 && dma_n == d; i++) @(posedge clk);
    #1;
  endtask : wait_dma

  initial begin
    void'($urandom(32'hf04f_0121));
    {rst, hsel, hwrite, rd_dp} = 4'h8;
    haddr = 8'h00;
    htrans = 2'b00;
    hsize = HSIZE_WORD;
    hwdata = RESET_WORD;
    {err_count, n_checks, cyc, trg_n, dma_n, last_pulse, last_gap} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b1, 8'h30, 32'hffff_ffff);
    foreach (ofs[i]) rd("reset or unmapped", ofs[i], RESET_WORD);
    // forced update under six chosen filter, trigger select and gate combinations
    foreach (rows[i]) begin
      row = rows[i];
      cv = 16'($urandom_range(65535, 1));
      bus(1'b1, OFS_CONTROL_ZERO, {28'h0, row[23:20]});
      bus(1'b1, OFS_CONTROL_ONE, {25'h0, row[18:16], 4'h0});
      bus(1'b1, OFS_IRQ_DMA_ENABLE, {20'h0, row[15:4]});
      bus(1'b1, OFS_COUNT_VALUE, {16'h0, cv});
      wait_n(4);
      rd("held count", OFS_COUNT_VALUE, {16'h0, cv});
      t0 = trg_n;
      d0 = dma_n;
      bus(1'b1, OFS_SOFT_EVENT, 32'h0000_0001);
      wait_n(3);
      check("trigger", {31'h0, row[2]}, 32'(trg_n - t0));
      check("dma", {31'h0, row[1]}, 32'(dma_n - d0));
      check("irq", {31'h0, row[3]}, {31'h0, update_irq});
      rd("cleared count", OFS_COUNT_VALUE, RESET_WORD);
      rd("force bit", OFS_SOFT_EVENT, RESET_WORD);
      rd("flag", OFS_EVENT_FLAGS, {31'h0, row[0]});
      bus(1'b1, OFS_EVENT_FLAGS, 32'h0000_0001);
      rd("flag after one", OFS_EVENT_FLAGS, {31'h0, row[0]});
      bus(1'b1, OFS_EVENT_FLAGS, 32'h0000_0000);
      rd("flag after zero", OFS_EVENT_FLAGS, RESET_WORD);
      check("irq off", 32'h0000_0000, {31'h0, update_irq});
    end
    // running: start trigger, period, prescale shadow
    p_old = 16'($urandom_range(3, 0));
    lim = 16'($urandom_range(8, 4));
    p_new = p_old + 16'($urandom_range(3, 1));
    bus(1'b1, OFS_CONTROL_ZERO, RESET_WORD);
    bus(1'b1, OFS_CONTROL_ONE, 32'h0000_0010);
    bus(1'b1, OFS_IRQ_DMA_ENABLE, 32'h0000_0100);
    bus(1'b1, OFS_CLOCK_DIVIDER, {16'h0, p_old});
    bus(1'b1, OFS_RELOAD_VALUE, {16'h0, lim});
    bus(1'b1, OFS_SOFT_EVENT, 32'h0000_0001);
    wait_n(2);
    t0 = trg_n;
    bus(1'b1, OFS_CONTROL_ZERO, 32'h0000_0001);
    wait_n(3);
    check("start trigger", 32'h0000_0001, 32'(trg_n - t0));
    wait_dma();
    wait_dma();
    gap_exp = (int'(p_old) + 1) * (int'(lim) + 1);
    check("period", 32'(gap_exp), 32'(last_gap));
    bus(1'b1, OFS_CLOCK_DIVIDER, {16'h0, p_new});
    wait_dma();
    check("old divider period", 32'(gap_exp), 32'(last_gap));
    wait_dma();
    gap_exp = (int'(p_new) + 1) * (int'(lim) + 1);
    check("new divider period", 32'(gap_exp), 32'(last_gap));
    // one shot: stops after the next overflow, run bit dropped
    bus(1'b1, OFS_CONTROL_ZERO, 32'h0000_0009);
    wait_dma();
    wait_n(3 * gap_exp);
    rd("one shot control", OFS_CONTROL_ZERO, 32'h0000_0008);
    rd("one shot count", OFS_COUNT_VALUE, RESET_WORD);
    wait_n(4);
    report_and_stop();
  end
endmodule : basic_upcount_timer_tb
`default_nettype wire
